// ==== hdl/driver_status_cfg.svh ====
// Constants for the driver status, OTP and clock trim register bank
`ifndef DRIVER_STATUS_CFG_SVH
`define DRIVER_STATUS_CFG_SVH

// Register addresses
`define ADDR_W 7
`define ADDR_GLOBAL_STATUS_FLAGS 7'h01
`define ADDR_INPUT_PIN_READBACK 7'h04
`define ADDR_OTP_PROGRAM_COMMAND 7'h06
`define ADDR_OTP_READ_DATA 7'h07
`define ADDR_OSCILLATOR_TRIM 7'h08
`define ADDR_SHORT_CONF 7'h09

// Global status flag positions
`define GLOBAL_STATUS_FLAGS_W 3
`define GLOBAL_STATUS_FLAGS_RESET_BIT 0
`define GLOBAL_STATUS_FLAGS_DRV_ERR_BIT 1
`define GLOBAL_STATUS_FLAGS_PUMP_UV_BIT 2

// Input readback layout
`define PIN_W 6
`define INPUT_PIN_READBACK_ONE_BIT 6
`define VERSION_LSB 24
`define VERSION_W 8
// Arbitrary neutral version code
`define VERSION_CODE 8'hA5

// OTP program command layout
`define OTP_BIT_LSB 0
`define OTP_BIT_W 3
`define OTP_BYTE_LSB 4
`define OTP_BYTE_W 2
`define OTP_KEY_LSB 8
`define OTP_KEY_W 8
`define OTP_KEY_VALUE 8'hBD
`define OTP_BYTES 4
`define OTP_BYTE_BITS 8
// Factory preset of OTP byte 0: trim code for nominal clock
`define OTP_BYTE0_FACTORY 8'h10
`define OTP_BLANK_BYTE 8'h00

// Clock trim and short level fields
`define TRIM_W 5
`define TRIM_RESET 5'h10
`define SHORT_LEVEL_W 4
`define SHORT_LEVEL_RESET 4'h6

`endif

// ==== hdl/driver_status_otp_regs.sv ====
// Global status, input readback, OTP access and clock trim register bank
`timescale 1ns/10ps
`default_nettype none
`include "driver_status_cfg.svh"

// Overview of operation
// - Status flags clear only by writing one; zero bits leave them alone.
// - Reset flag bit 0 is set whenever the device has been reset.
// - Bit 1 sets when driver stage shuts down for heat or short.
// - Driver error clear succeeds only while temperature is below limit.
// - Pump undervoltage disables driver while present and latches bit 2.
// - Input register returns live pins in bits 0..5, bit 6 reads one.
// - Bits 31..24 of input register give read-only silicon version code.
// - Each write to OTP program register programs exactly one bit.
// - Reading OTP program register refreshes OTP read data from array.
// - Bit select picks bit set to one; byte select written zero.
// - Programming needs key 0xBD in bits 15..8 on every write.
// - OTP read register shows OTP byte 0 in bits 7..0, read-only.
// - Five-bit trim code selects clock, lowest at 0, highest at 31.
// - After reset trim loads from OTP, preset for nominal clock.
// - Four-bit level sets low-side short-to-supply detection sensitivity.

module driver_status_otp_regs
    import driver_status_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire reg_req_t i_reg_req,
    input wire pin_t i_pins,
    input wire fault_t i_faults,
    output logic [31:0] o_reg_rdata,
    output logic o_reg_rvalid,
    output logic o_driver_off,
    output logic [`TRIM_W-1:0] o_clock_trim,
    output logic [`SHORT_LEVEL_W-1:0] o_supply_short_level,
    output logic o_otp_busy
);

    // Exact address match on the register port
    function automatic logic hit(
        input logic [`ADDR_W-1:0] addr,
        input logic [`ADDR_W-1:0] target
    );
        hit = (addr == target);
    endfunction : hit

    logic [`PIN_W-1:0] pins_sync;
    fault_t faults_sync;

    logic [`GLOBAL_STATUS_FLAGS_W-1:0] status_reg;
    logic [`GLOBAL_STATUS_FLAGS_W-1:0] status_next;
    logic [`OTP_BYTE_BITS-1:0] otp_mem_reg [`OTP_BYTES];
    logic [`OTP_BYTE_BITS-1:0] otp_read_reg;
    logic [`TRIM_W-1:0] trim_reg;
    logic [`SHORT_LEVEL_W-1:0] short_level_reg;
    logic [31:0] rdata_reg;
    logic rvalid_reg;
    otp_state_t otp_state_reg;
    otp_state_t otp_state_next;

    logic wr_status;
    logic wr_otp_program_command;
    logic rd_otp_program_command;
    logic wr_trim;
    logic wr_short;
    logic key_ok;
    logic [`OTP_BIT_W-1:0] prog_bit;
    logic [`OTP_BYTE_W-1:0] prog_byte;
    logic [31:0] read_mux;
    logic clr_reset;
    logic clr_drv_err;
    logic clr_pump_uv;
    logic drv_err_cause;
    logic otp_loading;
    logic prog_fire;
    logic otp_refresh;

    // Pins and analog fault comparators arrive from outside this clock
    sync_2ff #(
        .WIDTH(`PIN_W)
    ) u_pin_sync (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_async(i_pins),
        .o_sync(pins_sync)
    );

    sync_2ff #(
        .WIDTH($bits(fault_t))
    ) u_fault_sync (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_async(i_faults),
        .o_sync(faults_sync)
    );

    assign wr_status = i_reg_req.wr
        && hit(i_reg_req.addr, `ADDR_GLOBAL_STATUS_FLAGS);
    assign wr_otp_program_command = i_reg_req.wr
        && hit(i_reg_req.addr, `ADDR_OTP_PROGRAM_COMMAND);
    assign rd_otp_program_command = i_reg_req.rd
        && hit(i_reg_req.addr, `ADDR_OTP_PROGRAM_COMMAND);
    assign wr_trim = i_reg_req.wr
        && hit(i_reg_req.addr, `ADDR_OSCILLATOR_TRIM);
    assign wr_short = i_reg_req.wr
        && hit(i_reg_req.addr, `ADDR_SHORT_CONF);

    assign prog_bit = i_reg_req.wdata[`OTP_BIT_LSB +: `OTP_BIT_W];
    assign prog_byte = i_reg_req.wdata[`OTP_BYTE_LSB +: `OTP_BYTE_W];
    assign key_ok = (i_reg_req.wdata[`OTP_KEY_LSB +: `OTP_KEY_W]
        == `OTP_KEY_VALUE);

    // Program writes are ignored until the load after reset has finished
    assign otp_loading = (otp_state_reg == otp_load);
    assign prog_fire = wr_otp_program_command && key_ok
        && (otp_state_reg == otp_run);
    assign otp_refresh = otp_loading || rd_otp_program_command;

    // Write-one-to-clear update; a live cause outweighs a clear
    function automatic logic w1c_next(
        input logic flag,
        input logic cause,
        input logic clear
    );
        if (cause) begin
            w1c_next = 1'b1;
        end else if (clear) begin
            w1c_next = 1'b0;
        end else begin
            w1c_next = flag;
        end
    endfunction : w1c_next

    assign clr_reset = wr_status
        && i_reg_req.wdata[`GLOBAL_STATUS_FLAGS_RESET_BIT];
    assign clr_pump_uv = wr_status
        && i_reg_req.wdata[`GLOBAL_STATUS_FLAGS_PUMP_UV_BIT];
    // Driver error refuses the clear while still too hot
    assign clr_drv_err = wr_status
        && i_reg_req.wdata[`GLOBAL_STATUS_FLAGS_DRV_ERR_BIT]
        && !faults_sync.over_temp;
    assign drv_err_cause = faults_sync.over_temp
        || faults_sync.short_det;

    // Reset flag has no hardware cause once out of reset
    always_comb begin
        status_next[`GLOBAL_STATUS_FLAGS_RESET_BIT] = w1c_next(
            status_reg[`GLOBAL_STATUS_FLAGS_RESET_BIT], 1'b0, clr_reset);
        status_next[`GLOBAL_STATUS_FLAGS_DRV_ERR_BIT] = w1c_next(
            status_reg[`GLOBAL_STATUS_FLAGS_DRV_ERR_BIT], drv_err_cause, clr_drv_err);
        status_next[`GLOBAL_STATUS_FLAGS_PUMP_UV_BIT] = w1c_next(
            status_reg[`GLOBAL_STATUS_FLAGS_PUMP_UV_BIT], faults_sync.pump_uv,
            clr_pump_uv);
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            // Only the reset flag comes up set
            status_reg <= `GLOBAL_STATUS_FLAGS_W'(1) << `GLOBAL_STATUS_FLAGS_RESET_BIT;
        end else begin
            status_reg <= status_next;
        end
    end

    // Driver stays off for the live undervoltage and the latched driver error
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_driver_off <= 1'b1;
        end else begin
            o_driver_off <= faults_sync.pump_uv
                || status_next[`GLOBAL_STATUS_FLAGS_DRV_ERR_BIT];
        end
    end

    // OTP sequencer: load after reset, then serve program writes
    always_comb begin
        otp_state_next = otp_state_reg;
        unique case (otp_state_reg)
            otp_idle: begin
                otp_state_next = otp_load;
            end
            otp_load: begin
                otp_state_next = otp_run;
            end
            otp_run: begin
                otp_state_next = otp_run;
            end
            default: begin
                otp_state_next = otp_idle;
            end
        endcase
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            otp_state_reg <= otp_idle;
        end else begin
            otp_state_reg <= otp_state_next;
        end
    end

    assign o_otp_busy = (otp_state_reg != otp_run);

    // Fuse array; reset restores the factory image of the part
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            otp_mem_reg[0] <= `OTP_BYTE0_FACTORY;
            for (int i = 1; i < `OTP_BYTES; i++) begin
                otp_mem_reg[i] <= `OTP_BLANK_BYTE;
            end
        end else if (prog_fire) begin
            // Fuses only ever go to one, a single bit per write
            otp_mem_reg[prog_byte][prog_bit] <= 1'b1;
        end
    end

    // Read data holds its value until refreshed, so programming shows late
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            otp_read_reg <= `OTP_BLANK_BYTE;
        end else if (otp_refresh) begin
            otp_read_reg <= otp_mem_reg[0];
        end
    end

    // Trim loads from OTP once after reset, then software may override
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            trim_reg <= `TRIM_RESET;
        end else if (otp_loading) begin
            trim_reg <= otp_mem_reg[0][`TRIM_W-1:0];
        end else if (wr_trim) begin
            trim_reg <= i_reg_req.wdata[`TRIM_W-1:0];
        end
    end

    assign o_clock_trim = trim_reg;

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            short_level_reg <= `SHORT_LEVEL_RESET;
        end else if (wr_short) begin
            short_level_reg <= i_reg_req.wdata[`SHORT_LEVEL_W-1:0];
        end
    end

    assign o_supply_short_level = short_level_reg;

    // Read multiplexer; unmapped and write-only addresses read zero
    always_comb begin
        read_mux = 32'h0000_0000;
        unique case (i_reg_req.addr)
            `ADDR_GLOBAL_STATUS_FLAGS: begin
                read_mux[`GLOBAL_STATUS_FLAGS_W-1:0] = status_reg;
            end
            `ADDR_INPUT_PIN_READBACK: begin
                read_mux[`PIN_W-1:0] = pins_sync;
                read_mux[`INPUT_PIN_READBACK_ONE_BIT] = 1'b1;
                read_mux[`VERSION_LSB +: `VERSION_W] = `VERSION_CODE;
            end
            `ADDR_OTP_READ_DATA: begin
                read_mux[`OTP_BYTE_BITS-1:0] = otp_read_reg;
            end
            `ADDR_OSCILLATOR_TRIM: begin
                read_mux[`TRIM_W-1:0] = trim_reg;
            end
            default: begin
                read_mux = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            rdata_reg <= 32'h0000_0000;
        end else if (i_reg_req.rd) begin
            rdata_reg <= read_mux;
        end
    end

    // Valid trails the request by one clock, like the data
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            rvalid_reg <= 1'b0;
        end else begin
            rvalid_reg <= i_reg_req.rd;
        end
    end

    assign o_reg_rdata = rdata_reg;
    assign o_reg_rvalid = rvalid_reg;

endmodule : driver_status_otp_regs

`default_nettype wire

// ==== hdl/driver_status_pkg.sv ====
// Types shared by the driver status register bank
package driver_status_pkg;

    typedef struct packed {
        logic speed_ctrl_output_pin;
        logic driver_enable_low_pin;
        logic speed_ctrl_input_pin;
        logic speed_ctrl_enable_pin;
        logic dir;
        logic step;
    } pin_t;

    typedef struct packed {
        logic over_temp;
        logic short_det;
        logic pump_uv;
    } fault_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [6:0] addr;
        logic [31:0] wdata;
    } reg_req_t;

    typedef enum logic [1:0] {
        otp_idle,
        otp_load,
        otp_run
    } otp_state_t;

endpackage : driver_status_pkg

// ==== hdl/sync_2ff.sv ====
// Two flip-flop synchroniser for asynchronous level inputs
`timescale 1ns/10ps
`default_nettype none

module sync_2ff #(
    parameter int WIDTH = 1
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    // First stage feeds only the second stage
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= i_async;
            sync_reg <= meta_reg;
        end
    end

    assign o_sync = sync_reg;

endmodule : sync_2ff

`default_nettype wire

// ==== test/host_model.sv ====
// Host model driving the register request port
`timescale 1ns/10ps
`default_nettype none
`include "driver_status_cfg.svh"
module host_model
    import driver_status_pkg::*;
#(
    parameter int PROG_WAIT = 20
) (
    input wire logic i_clk,
    input wire logic [31:0] i_rdata,
    output var reg_req_t o_req
);
    initial o_req = '0;
    // Idle bus shows inverted address and data, never the last value
    task automatic access(input logic w, input logic [6:0] a,
        input logic [31:0] d, output logic [31:0] q);
        @(negedge i_clk);
        o_req = '{wr: w, rd: !w, addr: a, wdata: d};
        @(negedge i_clk);
        q = i_rdata;
        o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask : access
    // Wait stands for the programming time, shortened for simulation
    task automatic program_bit(input logic [2:0] b, input logic [7:0] key);
        logic [31:0] q;
        access(1'b1, `ADDR_OTP_PROGRAM_COMMAND, {16'h0, key, 5'h0, b}, q);
        repeat (PROG_WAIT) @(negedge i_clk);
    endtask : program_bit
endmodule : host_model
`default_nettype wire

// ==== test/reg_bank_monitor.sv ====
// Assertion checker for the status, OTP and trim register bank
`timescale 1ns/10ps
`default_nettype none
`include "driver_status_cfg.svh"
module reg_bank_monitor
    import driver_status_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire reg_req_t i_reg_req,
    input wire pin_t i_pins,
    input wire fault_t i_faults,
    input wire logic [31:0] o_reg_rdata,
    input wire logic o_reg_rvalid,
    input wire logic o_driver_off,
    input wire logic [`TRIM_W-1:0] o_clock_trim,
    input wire logic [`SHORT_LEVEL_W-1:0] o_supply_short_level,
    input wire logic o_otp_busy
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    sequence rd_at(logic [6:0] a);
        i_reg_req.rd && i_reg_req.addr == a;
    endsequence
    sequence wr_at(logic [6:0] a);
        i_reg_req.wr && i_reg_req.addr == a;
    endsequence
    // Two-flop sync plus register: four samples cover the lag
    sequence uv_held;
        i_faults.pump_uv [*4];
    endsequence
    sequence load_walk;
        o_otp_busy ##1 o_otp_busy ##1 !o_otp_busy;
    endsequence
    rvalid_follows_rd_a: assert property (
        o_reg_rvalid == $past(i_reg_req.rd))
        else $error("read valid not one cycle after read");
    pins_readback_a: assert property ($stable(i_pins) [*3] ##0
        rd_at(`ADDR_INPUT_PIN_READBACK) |=>
        o_reg_rdata[5:0] == $past(i_pins))
        else $error("pin readback wrong");
    version_field_a: assert property (rd_at(`ADDR_INPUT_PIN_READBACK) |=>
        o_reg_rdata[31:24] == `VERSION_CODE && o_reg_rdata[7:6] == 2'b01)
        else $error("version or fixed bits wrong");
    status_width_a: assert property (rd_at(`ADDR_GLOBAL_STATUS_FLAGS) |=>
        o_reg_rdata[31:3] == '0) else $error("status upper bits set");
    otp_width_a: assert property (rd_at(`ADDR_OTP_READ_DATA) |=>
        o_reg_rdata[31:8] == '0) else $error("otp read upper bits set");
    uv_disable_a: assert property (uv_held |-> o_driver_off)
        else $error("driver on during undervoltage");
    otp_load_a: assert property ($fell(i_sys_rst) |-> load_walk)
        else $error("otp load timing wrong");
    trim_write_a: assert property (
        wr_at(`ADDR_OSCILLATOR_TRIM) ##0 !o_otp_busy
        |=> o_clock_trim == $past(i_reg_req.wdata[4:0]))
        else $error("trim not written");
    level_write_a: assert property (wr_at(`ADDR_SHORT_CONF) |=>
        o_supply_short_level == $past(i_reg_req.wdata[3:0]))
        else $error("short level not written");
    rdata_hold_a: assert property (!i_reg_req.rd |=> $stable(o_reg_rdata))
        else $error("read data moved without read");
endmodule : reg_bank_monitor
bind driver_status_otp_regs reg_bank_monitor mon_u (.*);
`default_nettype wire

// ==== test/tb_top.sv ====
// Self-checking bench for the status, OTP and trim register bank
`timescale 1ns/10ps
`default_nettype none
`include "driver_status_cfg.svh"
module tb_top import driver_status_pkg::*;;
    logic clk = 1'b0;
    logic rst = 1'b1;
    pin_t pins = '0;
    fault_t flt = '0;
    reg_req_t req;
    logic [31:0] rdata, q;
    logic off;
    logic [`TRIM_W-1:0] trim;
    logic [`SHORT_LEVEL_W-1:0] lvl;
    int n_errors = 0;
    int checks_done = 0;
    int cyc = 0;
    initial forever #10 clk = ~clk;
    driver_status_otp_regs dut_u (.i_clk(clk), .i_sys_rst(rst),
        .i_reg_req(req), .i_pins(pins), .i_faults(flt),
        .o_reg_rdata(rdata), .o_reg_rvalid(), .o_driver_off(off),
        .o_clock_trim(trim), .o_supply_short_level(lvl), .o_otp_busy());
    host_model host_u (.i_clk(clk), .i_rdata(rdata), .o_req(req));
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic rd(input logic [6:0] a);
        host_u.access(1'b0, a, 32'h0, q);
    endtask : rd
    task automatic wr(input logic [6:0] a, input logic [31:0] d);
        host_u.access(1'b1, a, d, q);
    endtask : wr
    task automatic t_status();
        rd(`ADDR_GLOBAL_STATUS_FLAGS);
        chk("status_rst", q, 32'h1);
        wr(`ADDR_GLOBAL_STATUS_FLAGS, 32'h6);
        rd(`ADDR_GLOBAL_STATUS_FLAGS);
        chk("status_w0", q, 32'h1);
        wr(`ADDR_GLOBAL_STATUS_FLAGS, 32'h1);
        rd(`ADDR_GLOBAL_STATUS_FLAGS);
        chk("status_w1", q, 32'h0);
        rd(7'h7F);
        chk("unmapped", q, 32'h0);
    endtask : t_status
    task automatic t_pins();
        pin_t pv[2] = '{6'h15, 6'h2A};
        foreach (pv[k]) begin
            pins = pv[k];
            repeat (3) @(negedge clk);
            rd(`ADDR_INPUT_PIN_READBACK);
            chk("pins", q, {`VERSION_CODE, 17'h0, 1'b1, pv[k]});
        end
    endtask : t_pins
    // Overtemperature and short both latch the driver error flag
    task automatic t_faults();
        fault_t fv[2] = '{3'b100, 3'b010};
        foreach (fv[k]) begin
            flt = fv[k];
            repeat (4) @(negedge clk);
            wr(`ADDR_GLOBAL_STATUS_FLAGS, 32'h2);
            rd(`ADDR_GLOBAL_STATUS_FLAGS);
            chk("drv_err_held", q, 32'h2);
            chk("off_err", off, 1'b1);
            flt = '0;
            repeat (4) @(negedge clk);
            wr(`ADDR_GLOBAL_STATUS_FLAGS, 32'h2);
            rd(`ADDR_GLOBAL_STATUS_FLAGS);
            chk("drv_err_clr", q, 32'h0);
        end
        flt = 3'b001;
        repeat (4) @(negedge clk);
        chk("off_uv", off, 1'b1);
        flt = '0;
        repeat (4) @(negedge clk);
        chk("on_after_uv", off, 1'b0);
        rd(`ADDR_GLOBAL_STATUS_FLAGS);
        chk("uv_latched", q, 32'h4);
    endtask : t_faults
    task automatic t_trim();
        rd(`ADDR_OSCILLATOR_TRIM);
        chk("trim_rst", q, 32'(`OTP_BYTE0_FACTORY) & 32'h1F);
        for (int c = 0; c < 32; c += 31) begin
            wr(`ADDR_OSCILLATOR_TRIM, 32'(c));
            chk("trim_out", trim, 32'(c));
            rd(`ADDR_OSCILLATOR_TRIM);
            chk("trim_rd", q, 32'(c));
        end
        wr(`ADDR_SHORT_CONF, 32'hC);
        chk("level", lvl, 32'hC);
    endtask : t_trim
    task automatic t_otp();
        host_u.program_bit(3'd5, 8'h42);
        rd(`ADDR_OTP_PROGRAM_COMMAND);
        rd(`ADDR_OTP_READ_DATA);
        chk("otp_badkey", q, 32'(`OTP_BYTE0_FACTORY));
        host_u.program_bit(3'd5, `OTP_KEY_VALUE);
        rd(`ADDR_OTP_READ_DATA);
        chk("otp_stale", q, 32'(`OTP_BYTE0_FACTORY));
        rd(`ADDR_OTP_PROGRAM_COMMAND);
        rd(`ADDR_OTP_READ_DATA);
        chk("otp_bit5", q, 32'(`OTP_BYTE0_FACTORY | 8'h20));
        host_u.program_bit(3'd0, `OTP_KEY_VALUE);
        rd(`ADDR_OTP_PROGRAM_COMMAND);
        rd(`ADDR_OTP_READ_DATA);
        chk("otp_bit0", q, 32'(`OTP_BYTE0_FACTORY | 8'h21));
    endtask : t_otp
    task automatic summarize();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : summarize
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            summarize();
        end
    end
    initial begin
        repeat (8) @(negedge clk);
        rst = 1'b0;
        t_status();
        t_pins();
        t_faults();
        t_trim();
        t_otp();
        summarize();
    end
endmodule : tb_top
`default_nettype wire
